// ### verilog/dtc_map.vh
/*
  Constants for the dual timer/counter: mode codes, widths and timing counts.
  Assumes inclusion by bare name from the timer design files.
*/
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
`define DTC_MODE_PRESCALED 2'h0
`define DTC_MODE_SIXTEEN 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3
`define DTC_PRESCALE_DIV 5'h1F
`define DTC_CLK_PER_MC 3
`define DTC_MC_CNT_W 2
`endif

// ### verilog/dtc_unit.v
/*
  One timer/counter register pair (low and high byte) with its four modes.
  Assumes a one-cycle count enable already qualified by gate and run control.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dtc_map.vh"
module dtc_unit (
  input wire clk_sys,
  input wire rst_n,
  input wire cnt_en,
  input wire [1:0] mode,
  input wire split_low_only,
  input wire hi_cnt_en,
  input wire load_en,
  input wire [15:0] load_value,
  output reg [15:0] count,
  output reg overflow,
  output reg hi_overflow
);
  reg [15:0] next_count;
  reg next_overflow;
  reg next_hi_overflow;
  always @* begin
    next_count = count;
    next_overflow = 1'b0;
    next_hi_overflow = 1'b0;
    if (cnt_en) begin
      case (mode)
        `DTC_MODE_PRESCALED: begin
          // Low five bits act as the divide-by-32 prescaler.
          if (count[4:0] == `DTC_PRESCALE_DIV) begin
            next_count[4:0] = 5'h00;
            next_count[15:8] = count[15:8] + 8'h01;
            next_overflow = (count[15:8] == 8'hFF);
          end else begin
            next_count[4:0] = count[4:0] + 5'h01;
          end
        end
        `DTC_MODE_SIXTEEN: begin
          next_count = count + 16'h0001;
          next_overflow = (count == 16'hFFFF);
        end
        `DTC_MODE_RELOAD: begin
          if (count[7:0] == 8'hFF) begin
            next_count[7:0] = count[15:8];
            next_overflow = 1'b1;
          end else begin
            next_count[7:0] = count[7:0] + 8'h01;
          end
        end
        default: begin
          if (split_low_only) begin
            next_count[7:0] = count[7:0] + 8'h01;
            next_overflow = (count[7:0] == 8'hFF);
          end
        end
      endcase
    end
    if (hi_cnt_en && mode == `DTC_MODE_SPLIT && split_low_only) begin
      next_count[15:8] = count[15:8] + 8'h01;
      next_hi_overflow = (count[15:8] == 8'hFF);
    end
    if (load_en) begin
      next_count = load_value;
    end
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      overflow <= 1'b0;
      hi_overflow <= 1'b0;
    end else begin
      count <= next_count;
      overflow <= next_overflow;
      hi_overflow <= next_hi_overflow;
    end
  end
endmodule // dtc_unit
`default_nettype wire

// ### verilog/dtc_top.v
/*
  Two timer/counters with timer or counter function, gating and four modes.
  Assumes clk_sys is the oscillator; a machine cycle is three clocks. Pins are
  asynchronous and are synchronised here. Control arrives on plain inputs.
  A pin edge reaches the count output a few machine cycles late, and pulses
  faster than a sixth of the clock are lost. Unit B in split mode holds its
  count, but a load still lands.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dtc_map.vh"
module dtc_top (
  input wire clk_sys,
  input wire rst_n,
  input wire count_input_a,
  input wire count_input_b,
  input wire gate_input_a,
  input wire gate_input_b,
  input wire mode_sel_hi_a,
  input wire mode_sel_lo_a,
  input wire mode_sel_hi_b,
  input wire mode_sel_lo_b,
  input wire counter_sel_a,
  input wire counter_sel_b,
  input wire gate_en_a,
  input wire gate_en_b,
  input wire run_a,
  input wire run_b,
  input wire load_a,
  input wire load_b,
  input wire [15:0] load_value_a,
  input wire [15:0] load_value_b,
  input wire overflow_clr_a,
  input wire overflow_clr_b,
  input wire overflow_clr_split,
  output reg [15:0] count_a,
  output reg [15:0] count_b,
  output reg overflow_flag_a,
  output reg overflow_flag_b,
  output reg overflow_flag_split
);
  reg [`DTC_MC_CNT_W-1:0] mc_div;
  reg mc_tick;
  wire [15:0] unit_count_a;
  wire [15:0] unit_count_b;
  wire unit_ovf_a;
  wire unit_ovf_b;
  wire unit_hi_ovf_a;
  wire [1:0] mode_a;
  wire [1:0] mode_b;
  wire [1:0] cnt_pin;
  wire [1:0] gate_pin;
  wire [1:0] counter_sel;
  wire [1:0] gate_en;
  wire [1:0] run;
  wire [1:0] qualified;
  wire en_a;
  wire en_b;
  wire b_stopped;
  wire split_hi_tick;

  // Mode codes are the plain numbers 0 to 3, upper select bit first.
  assign mode_a = {mode_sel_hi_a, mode_sel_lo_a};
  assign mode_b = {mode_sel_hi_b, mode_sel_lo_b};
  assign cnt_pin = {count_input_b, count_input_a};
  assign gate_pin = {gate_input_b, gate_input_a};
  assign counter_sel = {counter_sel_b, counter_sel_a};
  assign gate_en = {gate_en_b, gate_en_a};
  assign run = {run_b, run_a};

  // Machine-cycle enable: one pulse every three oscillator clocks.
  // The tick is registered, but the count enables also take the plain run, gate-enable and counter-select inputs.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mc_div <= 2'h0;
      mc_tick <= 1'b0;
    end else begin
      mc_tick <= (mc_div == 2'h2);
      if (mc_div == 2'h2) begin
        mc_div <= 2'h0;
      end else begin
        mc_div <= mc_div + 2'h1;
      end
    end
  end

  // Each count and gate pin passes two flip-flops before anything reads it.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_in
      reg pin_meta;
      reg pin_sync;
      reg gate_meta;
      reg gate_sync;
      reg pin_sample;
      reg pin_prev;
      wire edge_seen;
      wire gate_ok;
      wire source_tick;
      // Reset levels match the pins at rest, so no false edge follows reset.
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta <= 1'b1;
          pin_sync <= 1'b1;
          gate_meta <= 1'b0;
          gate_sync <= 1'b0;
        end else begin
          pin_meta <= cnt_pin[i];
          pin_sync <= pin_meta;
          gate_meta <= gate_pin[i];
          gate_sync <= gate_meta;
        end
      end
      // The pin is sampled once per machine cycle; a high sample followed
      // by a low one in the next machine cycle is one falling edge.
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pin_sample <= 1'b1;
          pin_prev <= 1'b1;
        end else if (mc_tick) begin
          pin_sample <= pin_sync;
          pin_prev <= pin_sample;
        end
      end
      assign edge_seen = pin_prev & ~pin_sample;
      // Counting needs the run control, and with gating on also a high gate.
      assign gate_ok = ~gate_en[i] | gate_sync;
      assign source_tick = counter_sel[i] ? edge_seen : 1'b1;
      assign qualified[i] = mc_tick & run[i] & gate_ok & source_tick;
    end
  endgenerate

  // Unit B in split mode holds its count; its load path stays live.
  assign b_stopped = (mode_b == `DTC_MODE_SPLIT);
  assign en_a = qualified[0];
  assign en_b = qualified[1] & ~b_stopped;

  // In split mode the upper byte of unit A is a plain timer on unit B's run bit.
  assign split_hi_tick = mc_tick & run_b;

  dtc_unit u_unit_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cnt_en(en_a),
    .mode(mode_a),
    .split_low_only(1'b1),
    .hi_cnt_en(split_hi_tick),
    .load_en(load_a),
    .load_value(load_value_a),
    .count(unit_count_a),
    .overflow(unit_ovf_a),
    .hi_overflow(unit_hi_ovf_a)
  );

  // Unit B never splits, so its upper timer input is tied off.
  dtc_unit u_unit_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cnt_en(en_b),
    .mode(mode_b),
    .split_low_only(1'b0),
    .hi_cnt_en(1'b0),
    .load_en(load_b),
    .load_value(load_value_b),
    .count(unit_count_b),
    .overflow(unit_ovf_b),
    .hi_overflow()
  );

  // The count outputs are registered copies, so every port leaves a flip-flop.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_a <= 16'h0000;
      count_b <= 16'h0000;
    end else begin
      count_a <= unit_count_a;
      count_b <= unit_count_b;
    end
  end

  // Overflow flags are sticky. A set in the clearing cycle wins, so a wrap that
  // lands on the clear pulse is never lost.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_a <= 1'b0;
    end else if (unit_ovf_a) begin
      overflow_flag_a <= 1'b1;
    end else if (overflow_clr_a) begin
      overflow_flag_a <= 1'b0;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_b <= 1'b0;
    end else if (unit_ovf_b) begin
      overflow_flag_b <= 1'b1;
    end else if (overflow_clr_b) begin
      overflow_flag_b <= 1'b0;
    end
  end

  // The split flag belongs to the upper timer of unit A and rises only in split mode.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_split <= 1'b0;
    end else if (unit_hi_ovf_a) begin
      overflow_flag_split <= 1'b1;
    end else if (overflow_clr_split) begin
      overflow_flag_split <= 1'b0;
    end
  end
endmodule // dtc_top
`default_nettype wire

// ### tb/dtc_checker.sv
/* Concurrent checks on the dtc_top ports.
   Assumes a single clock domain and a bind by port name. */
`timescale 1ns/10ps
`default_nettype none
module dtc_checker (
  input wire clk_sys,
  input wire rst_n,
  input wire mode_sel_hi_a,
  input wire mode_sel_lo_a,
  input wire mode_sel_hi_b,
  input wire mode_sel_lo_b,
  input wire counter_sel_a,
  input wire gate_en_a,
  input wire gate_input_a,
  input wire run_a,
  input wire run_b,
  input wire load_a,
  input wire load_b,
  input wire [15:0] count_a,
  input wire [15:0] count_b,
  input wire overflow_flag_a
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire [1:0] ma = {mode_sel_hi_a, mode_sel_lo_a};
  wire go = run_a && !load_a && !counter_sel_a && !gate_en_a;
  wire [12:0] pre = {count_a[15:8], count_a[4:0]};
  sequence s_run(m); (go && ma == m)[*8]; endsequence
  sequence s_tick; 16'(count_a - $past(count_a, 3)) == 16'h0001; endsequence
  property p_m1; s_run(2'h1) |-> s_tick; endproperty
  a_m1: assert property (p_m1)
    else $error("16-bit timer step wrong");
  property p_m0; s_run(2'h0) |-> 13'(pre - $past(pre, 3)) == 13'h0001; endproperty
  a_m0: assert property (p_m0)
    else $error("prescaled step wrong");
  property p_rl; s_run(2'h2) ##0 $past(count_a[7:0]) == 8'hFF && count_a[7:0] != 8'hFF
    |-> count_a[7:0] == count_a[15:8] && overflow_flag_a; endproperty
  a_rl: assert property (p_rl)
    else $error("reload wrong");
  property p_ovf; s_run(2'h1) ##0 count_a == 16'h0000 |-> overflow_flag_a; endproperty
  a_ovf: assert property (p_ovf)
    else $error("16-bit wrap without flag");
  property p_gate; (run_a && gate_en_a && !gate_input_a && !load_a)[*8] |-> $stable(count_a);
  endproperty
  a_gate: assert property (p_gate)
    else $error("counted with gate closed");
  property p_bstop; (mode_sel_hi_b && mode_sel_lo_b && !load_b)[*4] |-> $stable(count_b);
  endproperty
  a_bstop: assert property (p_bstop)
    else $error("unit B counted in split mode");
  property p_split; (ma == 2'h3 && run_b && !load_a)[*8]
    |-> 8'(count_a[15:8] - $past(count_a[15:8], 3)) == 8'h01; endproperty
  a_split: assert property (p_split)
    else $error("split upper timer step wrong");
  property p_cnt; (ma == 2'h1 && counter_sel_a && !load_a)[*3] ##0 $changed(count_a)
    |-> count_a == 16'($past(count_a) + 16'h0001) ##1 $stable(count_a)[*5]; endproperty
  a_cnt: assert property (p_cnt)
    else $error("pin count step wrong");
endmodule // dtc_checker
bind dtc_top dtc_checker chk (.*);
`default_nettype wire

// ### tb/dtc_pins.sv
/* Pin model for one unit: falling-edge count pulses and a gate level.
   Assumes clk_sys as time base; go starts a burst of n_pulse pulses. */
`timescale 1ns/10ps
`default_nettype none
module dtc_pins (
  input wire clk_sys,
  input wire [7:0] n_pulse,
  input wire go,
  input wire gate_req,
  output logic count_pin,
  output logic gate_pin
);
  assign gate_pin = gate_req;
  // Twelve clocks per pulse keeps the rate below a sixth of the clock.
  initial begin
    count_pin = 1'h1;
    forever begin
      @(posedge go);
      repeat (n_pulse) begin
        repeat (6) @(posedge clk_sys);
        #1 count_pin = 1'h0;
        repeat (6) @(posedge clk_sys);
        #1 count_pin = 1'h1;
      end
    end
  end
endmodule // dtc_pins
`default_nettype wire

// ### tb/test_dtc_top.sv
/* Scenario bench for dtc_top.
   Assumes the checker is bound and dtc_pins drives the pins of unit A and unit B. */
`timescale 1ns/10ps
`default_nettype none
module test_dtc_top;
  logic clk_sys = 1'h0, rst_n = 1'h0, go = 1'h0, gq = 1'h0, pa, ga, hi_a = 1'h0, lo_a = 1'h0;
  logic hi_b = 1'h0, lo_b = 1'h0, cs = 1'h0, ge = 1'h0, ra = 1'h0, rb = 1'h0;
  logic cs_b = 1'h0, ge_b = 1'h0, go_b = 1'h0, gq_b = 1'h0, pb, gb;
  logic ld_a = 1'h0, ld_b = 1'h0, clr = 1'h0, of_a, of_b, of_s;
  logic [15:0] lv_a = 16'h0000, lv_b = 16'h0000, count_a, count_b;
  int n_fail = 0, n_compared = 0;
  dtc_pins pins (.clk_sys(clk_sys), .n_pulse(8'h05), .go(go), .gate_req(gq),
    .count_pin(pa), .gate_pin(ga));
  dtc_pins pins_b (.clk_sys(clk_sys), .n_pulse(8'h05), .go(go_b), .gate_req(gq_b),
    .count_pin(pb), .gate_pin(gb));
  dtc_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .count_input_a(pa), .count_input_b(pb),
    .gate_input_a(ga), .gate_input_b(gb), .mode_sel_hi_a(hi_a), .mode_sel_lo_a(lo_a),
    .mode_sel_hi_b(hi_b), .mode_sel_lo_b(lo_b), .counter_sel_a(cs), .counter_sel_b(cs_b),
    .gate_en_a(ge), .gate_en_b(ge_b), .run_a(ra), .run_b(rb), .load_a(ld_a), .load_b(ld_b),
    .load_value_a(lv_a), .load_value_b(lv_b), .overflow_clr_a(clr), .overflow_clr_b(clr),
    .overflow_clr_split(clr), .count_a(count_a), .count_b(count_b),
    .overflow_flag_a(of_a), .overflow_flag_b(of_b), .overflow_flag_split(of_s));
  initial forever #20 clk_sys = ~clk_sys;
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ld(input logic [15:0] v);
    lv_a = v;
    ld_a = 1'h1;
    tk(1);
    ld_a = 1'h0;
    tk(3);
  endtask
  task automatic wt(input logic [15:0] v);
    for (int i = 0; i < 600 && count_a !== v; i++) tk(1);
    chk("count a", v, count_a);
  endtask
  task automatic t_m1();
    {hi_a, lo_a} = 2'h1;
    ld(16'hFFF0);
    ra = 1'h1;
    wt(16'h0000);
    chk("flag a", 16'h0001, {15'h0000, of_a});
    ra = 1'h0;
    clr = 1'h1;
    tk(1);
    clr = 1'h0;
    tk(3);
    chk("flag a cleared", 16'h0000, {15'h0000, of_a});
    $display("t_m1 done");
  endtask
  task automatic t_m0();
    {hi_a, lo_a} = 2'h0;
    ld(16'h001F);
    ra = 1'h1;
    wt(16'h0100);
    tk(30);
    ra = 1'h0;
    $display("t_m0 done");
  endtask
  task automatic t_m2();
    {hi_a, lo_a} = 2'h2;
    ld(16'h70F0);
    ra = 1'h1;
    wt(16'h7070);
    chk("reload flag", 16'h0001, {15'h0000, of_a});
    wt(16'h7071);
    ra = 1'h0;
    $display("t_m2 done");
  endtask
  task automatic t_cnt();
    {hi_a, lo_a} = 2'h1;
    cs = 1'h1;
    ld(16'h0000);
    ra = 1'h1;
    go = 1'h1;
    tk(90);
    chk("pin count", 16'h0005, count_a);
    go = 1'h0;
    ra = 1'h0;
    cs = 1'h0;
    $display("t_cnt done");
  endtask
  task automatic t_gate();
    ge = 1'h1;
    ld(16'h1234);
    ra = 1'h1;
    tk(30);
    chk("gated count", 16'h1234, count_a);
    gq = 1'h1;
    wt(16'h1235);
    ra = 1'h0;
    ge = 1'h0;
    gq = 1'h0;
    $display("t_gate done");
  endtask
  task automatic t_b();
    {hi_b, lo_b} = 2'h1;
    cs_b = 1'h1;
    ge_b = 1'h1;
    lv_b = 16'hFFFE;
    ld_b = 1'h1;
    tk(1);
    ld_b = 1'h0;
    tk(3);
    rb = 1'h1;
    go_b = 1'h1;
    tk(90);
    chk("gated pin count b", 16'hFFFE, count_b);
    go_b = 1'h0;
    gq_b = 1'h1;
    tk(1);
    go_b = 1'h1;
    tk(90);
    chk("pin count b", 16'h0003, count_b);
    chk("flag b", 16'h0001, {15'h0000, of_b});
    {go_b, gq_b, rb, cs_b, ge_b, hi_b, lo_b} = 7'h00;
    $display("t_b done");
  endtask
  task automatic t_split();
    ld(16'hFB00);
    lv_b = 16'h00AA;
    ld_b = 1'h1;
    tk(1);
    ld_b = 1'h0;
    {hi_a, lo_a, hi_b, lo_b} = 4'hF;
    rb = 1'h1;
    wt(16'h0000);
    chk("unit b held", 16'h00AA, count_b);
    chk("split flag", 16'h0001, {15'h0000, of_s});
    rb = 1'h0;
    $display("t_split done");
  endtask
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    tk(20);
    rst_n = 1'h1;
    tk(2);
    t_m1();
    t_m0();
    t_m2();
    t_cnt();
    t_gate();
    t_b();
    t_split();
    wrap_up();
  end
  initial begin
    tk(20000);
    n_fail++;
    wrap_up();
  end
endmodule // test_dtc_top
`default_nettype wire
